// File: hdl/esa_defs.svh
// constants for the error status aggregator
// How it works
// RULE1: bits 6,5,4 mirror supply, electrometer, filter bytes
// RULE2: bits 3,1,0 mirror multiplier, filament, link bytes
// RULE3: summary bits 7 and 2 read zero
// RULE4: zero summary means no error detected
// RULE5: error LED steady while bits 1-7 set
// RULE6: link error bit flashes error LED twice
// RULE7: burnt, leak LEDs light on emission shutdown
// RULE8: power-on runs supply, electrometer, filter checks
// RULE9: hardware commands check, then return summary
// RULE10: each fault byte readable by own query
// RULE11: filament overpressure monitor shuts filament off
// RULE12: supply below 22 V sets supply bit 6
// RULE13: failed supply check: power LED off, error on
// RULE14: host polls summary regularly
// RULE15: some queries rerun tests, others clear on read
`ifndef ESA_DEFS_SVH
`define ESA_DEFS_SVH

// summary bit positions
`define ESA_SUM_SUPPLY   6
`define ESA_SUM_ELEC     5
`define ESA_SUM_MF       4
`define ESA_SUM_MULT     3
`define ESA_SUM_FIL      1
`define ESA_SUM_LINK     0

// fault byte field positions
`define ESA_SUPPLY_LOW_BIT  6
`define ESA_FIL_SHUT_BIT    6
`define ESA_LINK_BADCMD_BIT 0

// reset values
`define ESA_FAULT_RST    8'h00

// supply threshold and timing
`define ESA_SUPPLY_MIN_V    22
`define ESA_CLK_HZ          40000000
`define ESA_FLASH_HALF_MS   250
`define ESA_FLASH_CYCLES    (`ESA_FLASH_HALF_MS * (`ESA_CLK_HZ / 1000))
`define ESA_FLASH_PHASES    3'h4

`endif

// File: hdl/esa_pkg.sv
// types shared by the error status aggregator
package esa_pkg;

  // command codes on the serial command link
  typedef enum logic [3:0] {
    CMD_SUMMARY_Q  = 4'h0,
    CMD_SUPPLY_Q   = 4'h1,
    CMD_ELEC_Q     = 4'h2,
    CMD_MF_Q       = 4'h3,
    CMD_MULT_Q     = 4'h4,
    CMD_FIL_Q      = 4'h5,
    CMD_LINK_Q     = 4'h6,
    CMD_FIL_ON     = 4'h7,
    CMD_FIL_OFF    = 4'h8,
    CMD_HW_CHECK   = 4'h9
  } esa_cmd_e;

  // check identities, also index of the fault bytes
  typedef enum logic [2:0] {
    CHK_SUPPLY,
    CHK_ELEC,
    CHK_MF,
    CHK_MULT,
    CHK_FIL,
    CHK_LINK
  } esa_chk_e;

  typedef enum logic [1:0] {
    S_START,
    S_WAIT,
    S_REPLY,
    S_IDLE
  } esa_state_e;

  typedef struct packed {
    logic       valid;
    logic [3:0] code;
  } esa_cmd_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } esa_rsp_t;

  typedef struct packed {
    logic supply_low;
    logic overpressure;
    logic emission_fail;
  } esa_pins_t;

endpackage

// File: hdl/esa_top.sv
// error summary, fault bytes, query handling and indicator LEDs
`timescale 1ns/1ps
`include "esa_defs.svh"
module esa_top
  import esa_pkg::*;
#(
  parameter int unsigned FLASH_CYCLES = `ESA_FLASH_CYCLES
)
(
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // serial command link, decoded
  input  wire esa_cmd_t   cmd,
  output esa_rsp_t        rsp,
  output logic            cmd_ready,
  // check engines
  output logic            chk_start,
  output esa_chk_e        chk_sel,
  input  wire logic       chk_done,
  input  wire esa_chk_e   chk_id,
  input  wire logic [7:0] chk_bits,
  input  wire logic [7:0] link_err_bits,
  // analog monitor pins
  input  wire esa_pins_t  pins,
  // filament and indicators
  output logic            filament_en,
  output logic            power_led,
  output logic            error_led,
  output logic            burnt_led,
  output logic            leak_led,
  output logic [7:0]      error_summary
);

  localparam int NBYTES = 6;

  esa_pins_t  pin_meta;
  esa_pins_t  pin_sync;
  esa_state_e state;
  esa_chk_e   run_sel;
  logic       por_busy;
  logic       por_done;
  logic       reply_summary;
  logic [7:0] fault_q [NBYTES];
  logic [7:0] set_v   [NBYTES];
  logic [5:0] load_v;
  logic [5:0] clr_v;
  logic [7:0] next_summary;
  logic       accept;
  logic       fil_trip;
  logic       prev_link;
  logic [2:0] flash_left;
  logic [23:0] flash_cnt;

  // summary position of each fault byte
  function automatic int sum_pos(input int idx);
    case (idx)
      0:       sum_pos = `ESA_SUM_SUPPLY;
      1:       sum_pos = `ESA_SUM_ELEC;
      2:       sum_pos = `ESA_SUM_MF;
      3:       sum_pos = `ESA_SUM_MULT;
      4:       sum_pos = `ESA_SUM_FIL;
      default: sum_pos = `ESA_SUM_LINK;
    endcase
  endfunction

  // queries that rerun their hardware test first
  function automatic logic reruns(input logic [3:0] code);
    reruns = (code == CMD_SUPPLY_Q) || (code == CMD_ELEC_Q)
          || (code == CMD_MF_Q);
  endfunction

  // commands that hand over to a check engine
  function automatic logic starts_check(input logic [3:0] code);
    starts_check = reruns(code) || (code == CMD_FIL_ON)
                || (code == CMD_HW_CHECK);
  endfunction

  // fault byte addressed by a query code
  function automatic esa_chk_e query_target(input logic [3:0] code);
    case (code)
      CMD_SUPPLY_Q: query_target = CHK_SUPPLY;
      CMD_ELEC_Q:   query_target = CHK_ELEC;
      CMD_MF_Q:     query_target = CHK_MF;
      CMD_MULT_Q:   query_target = CHK_MULT;
      CMD_FIL_Q:    query_target = CHK_FIL;
      default:      query_target = CHK_LINK;
    endcase
  endfunction

  // two-flop synchroniser on the monitor pins
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      pin_meta <= '0;
      pin_sync <= '0;
    end
    else
    begin
      pin_meta <= pins;
      pin_sync <= pin_meta;
    end
  end

  assign accept   = (state == S_IDLE) && cmd.valid;
  assign fil_trip = filament_en
                 && (pin_sync.overpressure || pin_sync.emission_fail);

  // set, load and clear terms for every fault byte
  always_comb
  begin
    for (int i = 0; i < NBYTES; i++)
      set_v[i] = 8'h00;
    set_v[CHK_SUPPLY][`ESA_SUPPLY_LOW_BIT] = pin_sync.supply_low; // RULE12
    set_v[CHK_FIL][`ESA_FIL_SHUT_BIT] = fil_trip; // RULE11
    set_v[CHK_LINK] = link_err_bits;
    if (accept && (cmd.code > CMD_HW_CHECK))
      set_v[CHK_LINK][`ESA_LINK_BADCMD_BIT] = 1'b1;
    load_v = 6'h00;
    if ((state == S_WAIT) && chk_done && (chk_id == run_sel))
      load_v[run_sel] = 1'b1;
    clr_v = 6'h00;
    if (accept && ((cmd.code == CMD_MULT_Q) || (cmd.code == CMD_FIL_Q)
        || (cmd.code == CMD_LINK_Q)))
      clr_v[query_target(cmd.code)] = 1'b1; // RULE15
  end

  // fault bytes: fresh test loads, set beats clear
  generate
    for (genvar g = 0; g < NBYTES; g++)
    begin : g_fault
      always_ff @(posedge core_clk or posedge rst)
      begin
        if (rst)
          fault_q[g] <= `ESA_FAULT_RST;
        else if (load_v[g])
          fault_q[g] <= chk_bits | set_v[g]; // RULE15
        else
          fault_q[g] <= (clr_v[g] ? 8'h00 : fault_q[g]) | set_v[g];
      end
    end
  endgenerate

  // summary roll-up, unused bits held at zero
  always_comb
  begin
    next_summary = 8'h00; // RULE3
    for (int i = 0; i < NBYTES; i++)
      next_summary[sum_pos(i)] = |fault_q[i]; // RULE1 RULE2 RULE4
  end

  // sequencer for power-on checks, reruns and hardware commands
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      state         <= S_START;
      run_sel       <= CHK_SUPPLY;
      por_busy      <= 1'b1;
      reply_summary <= 1'b0;
      chk_start     <= 1'b0;
      chk_sel       <= CHK_SUPPLY;
      cmd_ready     <= 1'b0;
    end
    else
    begin
      chk_start <= 1'b0;
      case (state)
        S_START:
        begin
          chk_start <= 1'b1;
          chk_sel   <= run_sel;
          state     <= S_WAIT;
        end
        S_WAIT:
        begin
          if (chk_done && (chk_id == run_sel))
          begin
            if (!por_busy)
              state <= S_REPLY;
            else if (run_sel == CHK_MF)
            begin
              por_busy  <= 1'b0; // RULE8
              state     <= S_IDLE;
              cmd_ready <= 1'b1;
            end
            else
            begin
              run_sel <= esa_chk_e'(run_sel + 3'h1); // RULE8
              state   <= S_START;
            end
          end
        end
        S_REPLY:
        begin
          state     <= S_IDLE;
          cmd_ready <= 1'b1;
        end
        default:
        begin
          if (accept && starts_check(cmd.code))
          begin
            cmd_ready <= 1'b0;
            state     <= S_START;
            if (reruns(cmd.code))
            begin
              run_sel       <= query_target(cmd.code); // RULE15
              reply_summary <= 1'b0;
            end
            else
            begin
              run_sel <= (cmd.code == CMD_FIL_ON) ? CHK_FIL : CHK_MULT;
              reply_summary <= 1'b1; // RULE9
            end
          end
        end
      endcase
    end
  end

  // answers on the command link
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      rsp <= '0;
    else
    begin
      rsp.valid <= 1'b0;
      if (state == S_REPLY)
      begin
        rsp.valid <= 1'b1;
        rsp.data  <= reply_summary ? next_summary : fault_q[run_sel]; // RULE9
      end
      else if (accept && ((cmd.code == CMD_SUMMARY_Q)
               || (cmd.code == CMD_FIL_OFF)))
      begin
        rsp.valid <= 1'b1;
        rsp.data  <= next_summary; // RULE14
      end
      else if (accept && (cmd.code >= CMD_MULT_Q)
               && (cmd.code <= CMD_LINK_Q))
      begin
        rsp.valid <= 1'b1;
        rsp.data  <= fault_q[query_target(cmd.code)]; // RULE10
      end
    end
  end

  // filament enable with background overpressure protection
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
      filament_en <= 1'b0;
    else if (fil_trip)
      filament_en <= 1'b0; // RULE11
    else if (accept && (cmd.code == CMD_FIL_ON))
      filament_en <= 1'b1;
    else if (accept && (cmd.code == CMD_FIL_OFF))
      filament_en <= 1'b0;
  end

  // double flash when the link bit rises
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      prev_link  <= 1'b0;
      flash_left <= 3'h0;
      flash_cnt  <= 24'h000000;
    end
    else
    begin
      prev_link <= next_summary[`ESA_SUM_LINK];
      if (next_summary[`ESA_SUM_LINK] && !prev_link)
      begin
        flash_left <= `ESA_FLASH_PHASES; // RULE6
        flash_cnt  <= 24'h000000;
      end
      else if (flash_left != 3'h0)
      begin
        if (flash_cnt == 24'(FLASH_CYCLES - 1))
        begin
          flash_cnt  <= 24'h000000;
          flash_left <= flash_left - 3'h1;
        end
        else
          flash_cnt <= flash_cnt + 24'h000001;
      end
    end
  end

  // indicator LEDs and summary output
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      por_done      <= 1'b0;
      power_led     <= 1'b0;
      error_led     <= 1'b0;
      burnt_led     <= 1'b0;
      leak_led      <= 1'b0;
      error_summary <= 8'h00;
    end
    else
    begin
      por_done  <= por_done || !por_busy;
      power_led <= por_done && (fault_q[CHK_SUPPLY] == 8'h00); // RULE13
      error_led <= (|next_summary[7:1]) // RULE5 RULE13
                || ((flash_left != 3'h0) && !flash_left[0]); // RULE6
      burnt_led <= fault_q[CHK_FIL][`ESA_FIL_SHUT_BIT]; // RULE7
      leak_led  <= fault_q[CHK_FIL][`ESA_FIL_SHUT_BIT]; // RULE7
      error_summary <= next_summary; // RULE4
    end
  end

endmodule

// File: tb/esa_chk_model.sv
// check engine model answering the aggregator's check requests
`timescale 1ns/1ps
module esa_chk_model
  import esa_pkg::*;
(
  // clock and reset
  input  wire logic     core_clk,
  input  wire logic     rst,
  // check handshake
  input  wire logic     chk_start,
  input  wire esa_chk_e chk_sel,
  output logic          chk_done,
  output esa_chk_e      chk_id,
  output logic [7:0]    chk_bits
);
  logic [7:0] res [6];
  logic [2:0] wait_cnt;
  logic       busy;
  logic       slow;
  // answer each request, alternately at once and after a delay
  always_ff @(posedge core_clk or posedge rst)
    if (rst)
    begin
      busy     <= 1'b0;
      slow     <= 1'b0;
      wait_cnt <= 3'h0;
      chk_done <= 1'b0;
      chk_id   <= CHK_LINK;
      chk_bits <= 8'h5A;
    end
    else
    begin
      chk_done <= 1'b0;
      chk_id   <= esa_chk_e'(~chk_sel); // wrong id between answers
      chk_bits <= ~chk_bits; // never leave a stale result
      if (chk_start)
      begin
        busy     <= 1'b1;
        slow     <= ~slow;
        wait_cnt <= slow ? 3'h5 : 3'h0;
      end
      else if (busy && wait_cnt != 3'h0)
        wait_cnt <= wait_cnt - 3'h1;
      else if (busy)
      begin
        busy     <= 1'b0;
        chk_done <= 1'b1;
        chk_id   <= chk_sel;
        chk_bits <= res[chk_sel];
      end
    end
endmodule

// File: tb/esa_top_asserts.sv
// port assertions for the error status aggregator
`timescale 1ns/1ps
module esa_top_asserts
  import esa_pkg::*;
(
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // command link
  input wire esa_cmd_t   cmd,
  input wire logic       cmd_ready,
  input wire esa_rsp_t   rsp,
  input wire logic       chk_start,
  // pins and indicators
  input wire esa_pins_t  pins,
  input wire logic       filament_en,
  input wire logic       power_led,
  input wire logic       error_led,
  input wire logic       burnt_led,
  input wire logic       leak_led,
  input wire logic [7:0] error_summary
);
  // all checks on the core clock, quiet in reset
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  a_unused_zero: assert property (!error_summary[7]
    && !error_summary[2])
    else $error("unused summary bit set");
  a_led_steady: assert property ((|error_summary[7:1]) [*3]
    |-> error_led)
    else $error("error led dark with summary set");
  a_query_answer: assert property (cmd.valid && cmd_ready &&
    cmd.code == CMD_SUMMARY_Q |=> rsp.valid)
    else $error("summary query not answered");
  a_start_busy: assert property (chk_start |-> !cmd_ready ##1 !chk_start)
    else $error("check start while ready");
  a_fil_on: assert property (cmd.valid && cmd_ready &&
    cmd.code == CMD_FIL_ON |=> filament_en)
    else $error("filament not switched on");
  a_fil_shutoff: assert property (filament_en && pins.overpressure
    |-> ##[1:6] !filament_en)
    else $error("filament kept on in overpressure");
  a_burnt_error: assert property (burnt_led [*4]
    |-> error_led && leak_led)
    else $error("burnt without leak and error");
  a_supply_low: assert property (pins.supply_low [*6]
    |-> error_summary[6])
    else $error("low supply not summarised");
  a_power_off: assert property (error_summary[6] [*3] |-> !power_led)
    else $error("power led on with supply fault");
endmodule
bind esa_top esa_top_asserts esa_top_asserts_i (.core_clk(core_clk),
  .rst(rst), .cmd(cmd), .cmd_ready(cmd_ready), .rsp(rsp),
  .chk_start(chk_start), .pins(pins), .filament_en(filament_en),
  .power_led(power_led), .error_led(error_led), .burnt_led(burnt_led),
  .leak_led(leak_led), .error_summary(error_summary));

// File: tb/esa_top_tb.sv
// bench for the error status aggregator
`timescale 1ns/1ps
module esa_top_tb
  import esa_pkg::*;
;
  logic core_clk, rst, cmd_ready, chk_start, chk_done, filament_en;
  logic power_led, error_led, burnt_led, leak_led, led_q;
  logic [7:0] chk_bits, link_err_bits, error_summary, n;
  esa_cmd_t  cmd;
  esa_rsp_t  rsp;
  esa_pins_t pins;
  esa_chk_e  chk_sel, chk_id;
  int fails = 0, n_checks = 0, cyc = 0, k;
  esa_top #(.FLASH_CYCLES(4)) esa_top_i (.core_clk(core_clk), .rst(rst),
    .cmd(cmd), .rsp(rsp), .cmd_ready(cmd_ready), .chk_start(chk_start),
    .chk_sel(chk_sel), .chk_done(chk_done), .chk_id(chk_id),
    .chk_bits(chk_bits), .link_err_bits(link_err_bits), .pins(pins),
    .filament_en(filament_en), .power_led(power_led),
    .error_led(error_led), .burnt_led(burnt_led), .leak_led(leak_led),
    .error_summary(error_summary));
  esa_chk_model esa_chk_model_i (.core_clk(core_clk), .rst(rst),
    .chk_start(chk_start), .chk_sel(chk_sel), .chk_done(chk_done),
    .chk_id(chk_id), .chk_bits(chk_bits));
  // 40 MHz clock
  initial
  begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      fails = fails + 1;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic do_reset();
    rst = 1'b1;
    repeat (6) @(negedge core_clk);
    rst = 1'b0;
  endtask
  // one command pulse once the block is idle, one edge after the last
  task automatic send(input logic [3:0] code);
    int w = 0;
    @(negedge core_clk);
    while (cmd_ready !== 1'b1 && w < 200)
    begin
      @(negedge core_clk);
      w++;
    end
    if (w == 200)
      fails++;
    cmd = '{1'b1, code};
    @(negedge core_clk);
    cmd = '{1'b0, 4'h0};
  endtask
  task automatic query(input logic [3:0] code, input logic [7:0] exp);
    int w = 0;
    send(code);
    while (rsp.valid !== 1'b1 && w < 200)
    begin
      @(negedge core_clk);
      w++;
    end
    if (w == 200)
      fails++;
    chk(rsp.data, exp);
  endtask
  // main sequence
  initial
  begin
    cmd = '{1'b0, 4'h0};
    pins = '{1'b0, 1'b0, 1'b0};
    link_err_bits = 8'h00;
    for (k = 0; k < 6; k++)
      esa_chk_model_i.res[k] = 8'h00;
    do_reset();
    query(CMD_SUMMARY_Q, 8'h00);
    // power led follows the end of the power-on checks by two cycles
    repeat (2) @(negedge core_clk);
    chk({7'h00, power_led}, 8'h01);
    send(4'hF);
    n = 8'h00;
    led_q = 1'b0;
    repeat (40)
    begin
      @(negedge core_clk);
      if (error_led === 1'b1 && led_q === 1'b0)
        n++;
      led_q = error_led;
    end
    chk(n, 8'h02);
    chk(error_summary, 8'h01);
    link_err_bits = 8'h02;
    @(negedge core_clk);
    link_err_bits = 8'h00;
    query(CMD_LINK_Q, 8'h03);
    query(CMD_LINK_Q, 8'h00);
    $display("link test done");
    esa_chk_model_i.res[0] = 8'h40;
    esa_chk_model_i.res[1] = 8'h21;
    esa_chk_model_i.res[2] = 8'h80;
    for (k = 0; k < 3; k++)
      query(4'(k + 1), esa_chk_model_i.res[k]);
    query(CMD_SUMMARY_Q, 8'h70);
    chk({6'h00, power_led, error_led}, 8'h01);
    esa_chk_model_i.res[3] = 8'h11;
    query(CMD_HW_CHECK, 8'h78);
    query(CMD_MULT_Q, 8'h11);
    query(CMD_MULT_Q, 8'h00);
    $display("rerun and clear test done");
    query(CMD_FIL_ON, 8'h70);
    pins.overpressure = 1'b1;
    repeat (8) @(negedge core_clk);
    chk({5'h00, filament_en, burnt_led, leak_led}, 8'h03);
    chk(error_summary, 8'h72);
    pins.overpressure = 1'b0;
    query(CMD_FIL_Q, 8'h40);
    query(CMD_FIL_Q, 8'h00);
    query(CMD_FIL_OFF, 8'h70);
    // emission that cannot be held also shuts the filament down
    query(CMD_FIL_ON, 8'h70);
    pins.emission_fail = 1'b1;
    repeat (8) @(negedge core_clk);
    chk({5'h00, filament_en, burnt_led, leak_led}, 8'h03);
    pins.emission_fail = 1'b0;
    query(CMD_FIL_Q, 8'h40);
    $display("filament test done");
    for (k = 0; k < 3; k++)
      esa_chk_model_i.res[k] = 8'h00;
    do_reset();
    query(CMD_SUMMARY_Q, 8'h00);
    pins.supply_low = 1'b1;
    repeat (8) @(negedge core_clk);
    chk(error_summary, 8'h40);
    chk({6'h00, power_led, error_led}, 8'h01);
    $display("supply test done");
    tally_and_finish();
  end
endmodule
